// File: hdl/i2c_target_pkg.sv
// constants, carriers and states for the two-wire target engine
// assumes one core clock domain and one link sampling clock domain
package i2c_target_pkg;

   // widths
   localparam int ADDR_W = 10;
   localparam int BYTE_W = 8;
   localparam int CNT_W  = 4;

   // address literals and field positions
   localparam logic [4:0] WIDE_PREFIX = 5'h1E;
   localparam logic [7:0] BCAST_ADDR  = 8'h00;
   localparam int         DIR_BIT     = 0;
   localparam int         GC_CTRL_BIT = 15;

   // bit counts within one byte frame
   localparam logic [CNT_W-1:0] LAST_DATA_BIT = 4'h8;
   localparam logic [CNT_W-1:0] ACK_BIT       = 4'h9;

   // reset values
   localparam logic REL_RST = 1'b1;

   // software request indices in the toggle bus
   localparam int REQ_RX_READ  = 0;
   localparam int REQ_TX_WRITE = 1;
   localparam int REQ_REL_SET  = 2;
   localparam int REQ_REL_CLR  = 3;
   localparam int REQ_OVF_CLR  = 4;
   localparam int REQ_N        = 5;

   // static configuration levels
   typedef struct packed {
      logic              module_on;
      logic              wide_addr_sel;
      logic              rx_stretch_enable;
      logic              accept_all_addr;
      logic              broadcast_call_enable;
      logic [ADDR_W-1:0] own_addr_reg;
   } cfg_t;

   // status levels seen by software
   typedef struct packed {
      logic rx_full_flag;
      logic rx_overflow_flag;
      logic tx_full_flag;
      logic clock_release_bit;
      logic wide_match_flag;
   } status_t;

   // engine phases
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR2, ST_RX, ST_TX, ST_WAIT
   } eng_state_t;

endpackage : i2c_target_pkg

// File: hdl/i2c_target_with_clock_stretch.sv
// two-wire bus target engine with automatic and software clock stretch
// assumes SCL/SDA are open-drain wires resolved outside; the link clock
// oversamples them and runs free; software ports are core-clock pulses
`timescale 1ns/1ps
`default_nettype none

//
// Function
// - once on, wait for Start, then shift eight bits and compare address.
// - seven-bit mode compares own bits 6:0 to shift 7:1, bit 0 direction.
// - every incoming bit is sampled on the serial clock rising edge.
// - address match acks, target event at ninth fall, holding untouched.
// - read address enters transmit, acks, holds clock until load and release.
// - transmit shifts eight bits on falls; event at ninth fall regardless of ack.
// - write address receives eight bits, loads holding if empty, acks.
// - byte arriving while full is not acked nor loaded, event still raised.
// - overflow set but full clear loads holding yet answers not-ack.
// - wide first byte matches 11110 plus own 9:8; write clears wide match.
// - wide second byte matches own 7:0, sets or clears wide match flag.
// - after full wide match, repeated start with read enters transmit.
// - transmit always stretches at ninth fall on ack when buffer empty.
// - software may set release anytime; clock stays low until it does.
// - receive stretch enabled: ninth fall with full clears release, holds clock.
// - holding read between eighth and ninth fall leaves release set, no stretch.
// - wide mode with stretch enabled also stretches after address bytes.
// - software clear drives clock low only after a sampled falling edge.
// - with stretch disabled, software release clears are disregarded; sets act only while clear.
// - two event pulses: broadcast call received, target addressed.
// - accept-all control makes every own-address compare match; a wide read still needs a prior full match.
// - broadcast call loads holding and sets full if empty, controller event at ninth fall.
module i2c_target_with_clock_stretch
   import i2c_target_pkg::*;
(
   // core clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_srst,
   // configuration
   input  var  cfg_t              i_cfg,
   // software requests, one-cycle pulses
   input  wire logic              i_rx_read,
   input  wire logic              i_tx_write,
   input  wire logic [BYTE_W-1:0] i_tx_data,
   input  wire logic              i_rel_set,
   input  wire logic              i_rel_clr,
   input  wire logic              i_ovf_clr,
   // software view
   output var  status_t           o_status,
   output logic [BYTE_W-1:0]      o_rx_holding,
   output logic                   o_target_event,
   output logic                   o_controller_event,
   // link side
   input  wire logic              i_link_clk,
   input  wire logic              i_scl_in,
   input  wire logic              i_sda_in,
   output logic                   o_scl_out,
   output logic                   o_scl_oe,
   output logic                   o_sda_out,
   output logic                   o_sda_oe
);

   // ---------------- core domain ----------------
   logic [REQ_N-1:0]  req_tog_q;
   logic [BYTE_W-1:0] tx_data_q;
   status_t           st_s1_q, st_s2_q;
   logic [1:0]        ev_s1_q, ev_s2_q, ev_s3_q;
   logic              full_prev_q;
   logic [BYTE_W-1:0] rx_hold_q, tx_hold_q;
   logic [1:0]        ev_tog_q;
   status_t           st_link_q;

   // requests become toggles so a slow link clock never misses one
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         req_tog_q <= '0;
      end else begin
         req_tog_q <= req_tog_q ^ {i_ovf_clr, i_rel_clr, i_rel_set,
                                   i_tx_write, i_rx_read};
      end
   end

   // held until the next write; link reads it only after the toggle lands
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         tx_data_q <= '0;
      end else if (i_tx_write) begin
         tx_data_q <= i_tx_data;
      end
   end

   // status and event toggles back from the link
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_s1_q <= '0;
         st_s2_q <= '0;
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
      end else begin
         st_s1_q <= st_link_q;
         st_s2_q <= st_s1_q;
         ev_s1_q <= ev_tog_q;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end

   // outputs; holding is stable while full, so capture on full rising
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_status           <= '0;
         o_rx_holding       <= '0;
         full_prev_q        <= 1'b0;
         o_target_event     <= 1'b0;
         o_controller_event <= 1'b0;
      end else begin
         o_status           <= st_s2_q;
         full_prev_q        <= st_s2_q.rx_full_flag;
         o_target_event     <= ev_s2_q[0] ^ ev_s3_q[0];
         o_controller_event <= ev_s2_q[1] ^ ev_s3_q[1];
         if (st_s2_q.rx_full_flag && !full_prev_q) begin
            o_rx_holding <= rx_hold_q;
         end
      end
   end

   // ---------------- link domain ----------------
   logic              rst_s1_q, rst_l_q;
   cfg_t              cfg_s1_q, cfg_q;
   logic [REQ_N-1:0]  req_s1_q, req_s2_q, req_s3_q;
   logic [REQ_N-1:0]  req_ev;
   logic              scl_s1_q, scl_q, scl_prev_q;
   logic              sda_s1_q, sda_q, sda_prev_q;
   logic              scl_rise, scl_fall, start_det, stop_det;
   eng_state_t        state_q, nxt_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [BYTE_W-1:0] sh_q, tx_sh_q;
   logic              ack_q, ackin_q, load_q, need_load_q;
   logic              ev_tgt_q, ev_ctl_q, set_wm_q, clr_wm_q;
   logic              stretch_q, tx_go_q, fa_q;
   logic              rel_q, hold_q, stretch_now, byte_end;
   logic              m7, m10a, m10b, gc;

   // reset crosses as a level; config is static while the bus is in use
   always_ff @(posedge i_link_clk) begin
      rst_s1_q <= i_srst;
      rst_l_q  <= rst_s1_q;
      cfg_s1_q <= i_cfg;
      cfg_q    <= cfg_s1_q;
   end

   // pin and request synchronisers
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q) begin
         {scl_s1_q, scl_q, scl_prev_q} <= 3'h7;
         {sda_s1_q, sda_q, sda_prev_q} <= 3'h7;
         req_s1_q <= '0;
         req_s2_q <= '0;
         req_s3_q <= '0;
      end else begin
         {scl_s1_q, scl_q, scl_prev_q} <= {i_scl_in, scl_s1_q, scl_q};
         {sda_s1_q, sda_q, sda_prev_q} <= {i_sda_in, sda_s1_q, sda_q};
         req_s1_q <= req_tog_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   assign req_ev    = req_s2_q ^ req_s3_q;
   assign scl_rise  = scl_q && !scl_prev_q;
   assign scl_fall  = !scl_q && scl_prev_q;
   assign start_det = scl_q && scl_prev_q && !sda_q && sda_prev_q;
   assign stop_det  = scl_q && scl_prev_q && sda_q && !sda_prev_q;
   assign byte_end  = scl_fall && (cnt_q == ACK_BIT);

   // address compare on the full shifted byte
   assign m7   = (sh_q[7:1] == cfg_q.own_addr_reg[6:0])
                 || cfg_q.accept_all_addr;
   assign m10a = ((sh_q[7:3] == WIDE_PREFIX) &&
                  (sh_q[2:1] == cfg_q.own_addr_reg[9:8]))
                 || cfg_q.accept_all_addr;
   assign m10b = (sh_q == cfg_q.own_addr_reg[7:0])
                 || cfg_q.accept_all_addr;
   assign gc   = cfg_q.broadcast_call_enable && (sh_q == BCAST_ADDR);

   // bit counter and receive shifter
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q || !cfg_q.module_on || start_det) begin
         cnt_q <= '0;
         sh_q  <= '0;
      end else if (scl_rise && cnt_q < LAST_DATA_BIT) begin
         sh_q  <= {sh_q[6:0], sda_q};
         cnt_q <= cnt_q + 4'h1;
      end else if (scl_rise) begin
         cnt_q <= cnt_q + 4'h1;
      end else if (byte_end) begin
         cnt_q <= '0;
      end
   end

   // decision at the eighth fall, applied at the ninth fall
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q || !cfg_q.module_on) begin
         state_q <= ST_IDLE;
         nxt_q   <= ST_IDLE;
         {ack_q, load_q, ev_tgt_q, ev_ctl_q} <= '0;
         {set_wm_q, clr_wm_q, stretch_q, tx_go_q} <= '0;
      end else if (start_det) begin
         state_q <= ST_ADDR;
         ack_q   <= 1'b0;
      end else if (stop_det) begin
         state_q <= ST_IDLE;
         ack_q   <= 1'b0;
      end else if (scl_fall && cnt_q == LAST_DATA_BIT) begin
         {ack_q, load_q, ev_tgt_q, ev_ctl_q} <= '0;
         {set_wm_q, clr_wm_q, stretch_q, tx_go_q} <= '0;
         nxt_q <= ST_WAIT;
         unique case (state_q)
            ST_ADDR: begin
               if (gc && !sh_q[DIR_BIT]) begin
                  ack_q    <= !st_link_q.rx_full_flag;
                  load_q   <= !st_link_q.rx_full_flag;
                  ev_ctl_q <= 1'b1;
                  nxt_q    <= ST_RX;
               end else if (!cfg_q.wide_addr_sel && m7) begin
                  ack_q    <= 1'b1;
                  ev_tgt_q <= 1'b1;
                  tx_go_q  <= sh_q[DIR_BIT];
                  nxt_q    <= sh_q[DIR_BIT] ? ST_TX : ST_RX;
               end else if (cfg_q.wide_addr_sel && m10a && !sh_q[DIR_BIT]) begin
                  ack_q     <= 1'b1;
                  ev_tgt_q  <= 1'b1;
                  clr_wm_q  <= 1'b1;
                  stretch_q <= cfg_q.rx_stretch_enable;
                  nxt_q     <= ST_ADDR2;
               end else if (cfg_q.wide_addr_sel && m10a && fa_q) begin
                  ack_q    <= 1'b1;
                  ev_tgt_q <= 1'b1;
                  tx_go_q  <= 1'b1;
                  nxt_q    <= ST_TX;
               end else begin
                  clr_wm_q <= cfg_q.wide_addr_sel;
               end
            end
            ST_ADDR2: begin
               if (m10b) begin
                  ack_q     <= 1'b1;
                  ev_tgt_q  <= 1'b1;
                  set_wm_q  <= 1'b1;
                  stretch_q <= cfg_q.rx_stretch_enable;
                  nxt_q     <= ST_RX;
               end else begin
                  clr_wm_q <= 1'b1;
               end
            end
            ST_RX: begin
               ev_tgt_q <= 1'b1;
               nxt_q    <= ST_RX;
               load_q   <= !st_link_q.rx_full_flag;
               ack_q    <= !st_link_q.rx_full_flag &&
                           !st_link_q.rx_overflow_flag;
            end
            ST_TX: begin
               ev_tgt_q <= 1'b1;
               nxt_q    <= ST_TX;
            end
            default: begin
               nxt_q <= ST_WAIT;
            end
         endcase
      end else if (byte_end) begin
         ack_q   <= 1'b0;
         state_q <= (state_q == ST_TX && !ackin_q) ? ST_WAIT : nxt_q;
      end
   end

   // master acknowledge sampled on the ninth rise while transmitting
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q) begin
         ackin_q <= 1'b0;
      end else if (scl_rise && cnt_q == LAST_DATA_BIT) begin
         ackin_q <= !sda_q;
      end
   end

   // stretch requests at the ninth fall; a byte loaded there counts as unread
   always_comb begin
      stretch_now = 1'b0;
      if (byte_end) begin
         if (tx_go_q || (state_q == ST_TX && ackin_q)) begin
            stretch_now = !st_link_q.tx_full_flag;
         end else if (state_q == ST_RX) begin
            stretch_now = cfg_q.rx_stretch_enable &&
                          (st_link_q.rx_full_flag || load_q);
         end else begin
            stretch_now = stretch_q;
         end
      end
   end

   // transmit shifter; bits shift only on falls, bit 0 holds to the eighth
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q || !cfg_q.module_on || start_det) begin
         tx_sh_q     <= '1;
         need_load_q <= 1'b0;
      end else if (byte_end && (tx_go_q || (state_q == ST_TX && ackin_q))) begin
         tx_sh_q     <= st_link_q.tx_full_flag ? tx_hold_q : '1;
         need_load_q <= !st_link_q.tx_full_flag;
      end else if (need_load_q && st_link_q.tx_full_flag && !scl_q) begin
         tx_sh_q     <= tx_hold_q;
         need_load_q <= 1'b0;
      end else if (scl_fall && state_q == ST_TX && cnt_q > 4'h0
                   && cnt_q <= LAST_DATA_BIT) begin
         tx_sh_q <= {tx_sh_q[6:0], 1'b1};
      end
   end

   logic              tx_taken;
   assign tx_taken = (byte_end && st_link_q.tx_full_flag &&
                      (tx_go_q || (state_q == ST_TX && ackin_q)))
                     || (need_load_q && st_link_q.tx_full_flag && !scl_q);

   // buffer flags; a hardware set wins over a same-cycle clear
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q) begin
         st_link_q.rx_full_flag     <= 1'b0;
         st_link_q.rx_overflow_flag <= 1'b0;
         st_link_q.tx_full_flag     <= 1'b0;
         st_link_q.wide_match_flag  <= 1'b0;
         rx_hold_q                  <= '0;
         tx_hold_q                  <= '0;
         fa_q                       <= 1'b0;
         st_link_q.clock_release_bit <= REL_RST;
      end else begin
         st_link_q.clock_release_bit <= rel_q;
         if (byte_end && load_q) begin
            rx_hold_q              <= sh_q;
            st_link_q.rx_full_flag <= 1'b1;
         end else if (req_ev[REQ_RX_READ]) begin
            st_link_q.rx_full_flag <= 1'b0;
         end
         if (byte_end && state_q == ST_RX && !load_q) begin
            st_link_q.rx_overflow_flag <= 1'b1;
         end else if (req_ev[REQ_OVF_CLR]) begin
            st_link_q.rx_overflow_flag <= 1'b0;
         end
         if (req_ev[REQ_TX_WRITE]) begin
            tx_hold_q              <= tx_data_q;
            st_link_q.tx_full_flag <= 1'b1;
         end else if (tx_taken) begin
            st_link_q.tx_full_flag <= 1'b0;
         end
         if (byte_end && set_wm_q) begin
            st_link_q.wide_match_flag <= 1'b1;
            fa_q                      <= 1'b1;
         end else if (byte_end && clr_wm_q) begin
            st_link_q.wide_match_flag <= 1'b0;
            fa_q                      <= 1'b0;
         end else if (stop_det) begin
            fa_q <= 1'b0;
         end
      end
   end

   // release bit and clock hold
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q || !cfg_q.module_on) begin
         rel_q  <= REL_RST;
         hold_q <= 1'b0;
      end else begin
         if (stretch_now) begin
            rel_q <= 1'b0;
         end else if (req_ev[REQ_REL_SET] &&
                      (cfg_q.rx_stretch_enable || !rel_q)) begin
            rel_q <= 1'b1;
         end else if (req_ev[REQ_REL_CLR] && cfg_q.rx_stretch_enable) begin
            rel_q <= 1'b0;
         end
         if (rel_q && !stretch_now) begin
            hold_q <= 1'b0;
         end else if (stretch_now || (scl_fall && !rel_q)) begin
            hold_q <= 1'b1;
         end
      end
   end

   // event toggles and pin drivers, all from flops
   always_ff @(posedge i_link_clk) begin
      if (rst_l_q) begin
         ev_tog_q                    <= '0;
         o_scl_oe                    <= 1'b0;
         o_sda_oe                    <= 1'b0;
      end else begin
         if (byte_end) begin
            ev_tog_q <= ev_tog_q ^ {ev_ctl_q, ev_tgt_q};
         end
         o_scl_oe <= hold_q;
         o_sda_oe <= ack_q || (state_q == ST_TX && cnt_q <= LAST_DATA_BIT
                               && !need_load_q && !tx_sh_q[7]);
      end
   end

   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;

endmodule : i2c_target_with_clock_stretch

`default_nettype wire

// File: sim/i2c_target_props.sv
// checker for the two-wire target engine, watching its ports only
// assumes a core clock and a free-running link sampling clock
`timescale 1ns/1ps
`default_nettype none
module i2c_target_props
   import i2c_target_pkg::*;
(
   // clocks and reset
   input wire logic    i_core_clk,
   input wire logic    i_srst,
   input wire logic    i_link_clk,
   // watched inputs
   input var  cfg_t    i_cfg,
   input wire logic    i_rx_read,
   input wire logic    i_scl_in,
   // watched outputs
   input var  status_t o_status,
   input wire logic    o_target_event,
   input wire logic    o_controller_event,
   input wire logic    o_scl_oe,
   input wire logic    o_sda_oe
);
   // event outputs are single pulses; a controller event needs broadcast enable
   a_tev_one_pulse:
      assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_target_event |=> !o_target_event) else $error("target event too long");
   a_cev_needs_bcast:
      assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_controller_event |-> i_cfg.broadcast_call_enable ##1 !o_controller_event)
      else $error("controller event without broadcast enable");
   // a switched-off engine never pulls a line
   a_off_no_drive:
      assert property (@(posedge i_core_clk) disable iff (i_srst)
      !i_cfg.module_on [*8] |-> !o_sda_oe && !o_scl_oe) else $error("drive while off");
   // a stretch always comes with the release bit cleared
   a_stretch_clr_rel:
      assert property (@(posedge i_core_clk) disable iff (i_srst)
      $rose(o_scl_oe) |-> ##[1:8] !o_status.clock_release_bit) else $error("stretch, bit set");
   // a held clock lets go only once release is set
   a_release_ends_hold:
      assert property (@(posedge i_core_clk) disable iff (i_srst)
      $fell(o_scl_oe) |-> ##[0:8] o_status.clock_release_bit) else $error("early clock release");
   a_read_clears_full:
      assert property (@(posedge i_core_clk) disable iff (i_srst)
      i_rx_read && o_status.rx_full_flag |-> ##[1:8] !o_status.rx_full_flag)
      else $error("read left full flag set");
   // data moves only while the clock is low, so it is stable for sampling
   a_sda_moves_scl_low:
      assert property (@(posedge i_link_clk) disable iff (i_srst)
      $changed(o_sda_oe) |-> !i_scl_in) else $error("data changed with clock high");
   a_wide_needs_mode:
      assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_status.wide_match_flag |-> i_cfg.wide_addr_sel) else $error("wide match in short mode");
endmodule : i2c_target_props

bind i2c_target_with_clock_stretch i2c_target_props i_i2c_target_props (
   .i_core_clk(i_core_clk), .i_srst(i_srst), .i_link_clk(i_link_clk), .i_cfg(i_cfg),
   .i_rx_read(i_rx_read), .i_scl_in(i_scl_in), .o_status(o_status),
   .o_target_event(o_target_event), .o_controller_event(o_controller_event),
   .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));
`default_nettype wire

// File: sim/i2c_ctrl_model.sv
// bus controller model: start, stop and byte frames on open-drain lines
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   // resolved line levels
   input  wire logic i_scl,
   input  wire logic i_sda,
   // pull-low enables
   output logic      o_scl_oe,
   output logic      o_sda_oe
);
   localparam int HALF = 1000; // half bit period, ns; far above the 3 link cycles

   // released lines at power-up
   initial begin
      o_scl_oe = 1'b0;
      o_sda_oe = 1'b0;
   end

   // one clock pulse; data set well after the fall so it is not a start or stop
   task automatic pulse(input logic v, output logic s);
      #(HALF / 4);
      o_sda_oe = !v;
      #HALF;
      o_scl_oe = 1'b0;
      for (int n = 0; n < 20000 && i_scl !== 1'b1; n++) #10;
      #(HALF / 2);
      s = i_sda;
      #(HALF / 2);
      o_scl_oe = 1'b1;
   endtask : pulse

   // start, also usable as a repeated start from clock low
   task automatic start;
      o_sda_oe = 1'b0;
      #HALF;
      o_scl_oe = 1'b0;
      #HALF;
      o_sda_oe = 1'b1;
      #HALF;
      o_scl_oe = 1'b1;
   endtask : start

   task automatic stop;
      #(HALF / 4);
      o_sda_oe = 1'b1;
      #HALF;
      o_scl_oe = 1'b0;
      #HALF;
      o_sda_oe = 1'b0;
      #HALF;
   endtask : stop

   // eight bits msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] w, input logic m, output logic [7:0] r,
                       output logic a);
      for (int i = 7; i >= 0; i--) pulse(w[i], r[i]);
      pulse(m, a);
   endtask : xfer
endmodule : i2c_ctrl_model
`default_nettype wire

// File: sim/i2c_target_with_clock_stretch_tb.sv
// self-checking bench for the two-wire target engine with clock stretch
// assumes the controller model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module i2c_target_with_clock_stretch_tb;
   import i2c_target_pkg::*;
   // stimulus, lines and tallies
   logic             core_clk = 1'b0;
   logic             link_clk = 1'b0;
   logic             srst     = 1'b1;
   logic [REQ_N-1:0] req      = '0;
   logic [7:0]       tx_data  = 8'h00;
   cfg_t             cfg;
   status_t          st;
   logic [7:0]       rx_holding, r, d, hold;
   logic [6:0]       own;
   logic [9:0]       own10;
   logic             tev, cev, scl_oe, sda_oe, m_scl_oe, m_sda_oe, ack, scl_q;
   int               num_errors = 0, compares = 0, cycles = 0, t, ts;
   int               n_tev = 0, n_cev = 0, n_str = 0, full = 0, ovf = 0;
   wire logic        scl = !(scl_oe | m_scl_oe); // pull-up when nobody pulls
   wire logic        sda = !(sda_oe | m_sda_oe);

   // 50 and 48 ns periods, so the two phases drift
   always #25 core_clk = !core_clk;
   always #24 link_clk = !link_clk;

   // event and stretch tallies, cycle ceiling
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      scl_q  <= scl_oe;
      n_tev  <= n_tev + int'(tev === 1'b1);
      n_cev  <= n_cev + int'(cev === 1'b1);
      n_str  <= n_str + int'(scl_oe === 1'b1 && scl_q === 1'b0);
      if (cycles == 40000) begin
         num_errors = num_errors + 1;
         test_done();
      end
   end

   i2c_target_with_clock_stretch i_i2c_target_with_clock_stretch (
      .i_core_clk(core_clk), .i_srst(srst), .i_cfg(cfg), .i_rx_read(req[REQ_RX_READ]),
      .i_tx_write(req[REQ_TX_WRITE]), .i_tx_data(tx_data), .i_rel_set(req[REQ_REL_SET]),
      .i_rel_clr(req[REQ_REL_CLR]), .i_ovf_clr(req[REQ_OVF_CLR]), .o_status(st),
      .o_rx_holding(rx_holding), .o_target_event(tev), .o_controller_event(cev),
      .i_link_clk(link_clk), .i_scl_in(scl), .i_sda_in(sda), .o_scl_out(),
      .o_scl_oe(scl_oe), .o_sda_out(), .o_sda_oe(sda_oe));
   i2c_ctrl_model i_i2c_ctrl_model (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe),
      .o_sda_oe(m_sda_oe));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one software pulse, spaced for the toggle sync, then status settles
   task automatic sw(input int k, input logic [7:0] v = 8'h00);
      @(posedge core_clk);
      req[k]  <= 1'b1;
      tx_data <= v;
      @(posedge core_clk);
      req[k] <= 1'b0;
      repeat (10) @(posedge core_clk);
   endtask : sw

   task automatic xb(input logic [7:0] w, input logic m);
      i_i2c_ctrl_model.xfer(w, m, r, ack);
      repeat (12) @(posedge core_clk);
   endtask : xb

   task automatic ad(input logic [7:0] a, input logic nack);
      t = n_tev;
      i_i2c_ctrl_model.start();
      xb(a, 1'b1);
      chk(8'(ack), 8'(nack));
      chk(8'(n_tev - t), 8'(!nack));
   endtask : ad

   // received byte against the reference full and overflow flags
   task automatic rx(input logic [7:0] v);
      t = n_tev;
      xb(v, 1'b1);
      chk(8'(ack), 8'(full | ovf));
      if (full == 0) hold = v;
      ovf  = ovf | full;
      full = 1;
      chk(rx_holding, hold);
      chk({6'h00, st.rx_full_flag, st.rx_overflow_flag}, 8'(full * 2 + ovf));
      chk(8'(n_tev - t), 8'h01);
   endtask : rx

   task automatic test_done;
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   initial begin
      void'($urandom(32'hDF74));
      own   = 7'h04 + 7'($urandom % 112);
      own10 = 10'($urandom);
      cfg   = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, {3'h0, own}};
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      repeat (8) @(posedge core_clk);
      ad({own, 1'b0}, 1'b1);
      i_i2c_ctrl_model.stop();
      cfg.module_on <= 1'b1;
      sw(REQ_REL_CLR);
      chk(8'(st.clock_release_bit), 8'h01);
      ad({own ^ 7'h01, 1'b0}, 1'b1);
      ad({own, 1'b0}, 1'b0);
      chk(8'(st.rx_full_flag), 8'h00);
      rx(8'($urandom));
      rx(8'($urandom));
      sw(REQ_RX_READ);
      full = 0;
      rx(8'($urandom));
      sw(REQ_RX_READ);
      sw(REQ_OVF_CLR);
      full = 0;
      ovf  = 0;
      // any address accepted, then the broadcast call
      cfg.accept_all_addr <= 1'b1;
      ad({own ^ 7'h01, 1'b0}, 1'b0);
      rx(8'($urandom));
      sw(REQ_RX_READ);
      full = 0;
      cfg.accept_all_addr       <= 1'b0;
      cfg.broadcast_call_enable <= 1'b1;
      t = n_cev;
      i_i2c_ctrl_model.start();
      xb(BCAST_ADDR, 1'b1);
      chk({7'h00, ack}, 8'h00);
      chk(8'(n_cev - t), 8'h01);
      chk(rx_holding, BCAST_ADDR);
      sw(REQ_RX_READ);
      // transmit: stretch after address, none with a preloaded byte
      ts = n_str;
      ad({own, 1'b1}, 1'b0);
      chk(8'(scl_oe), 8'h01);
      d = 8'($urandom);
      sw(REQ_TX_WRITE, d);
      sw(REQ_REL_SET);
      fork
         xb(8'hFF, 1'b0);
         begin
            #6000;
            sw(REQ_TX_WRITE, ~d);
         end
      join
      chk(r, d);
      xb(8'hFF, 1'b1);
      chk(r, ~d);
      chk(8'(n_str - ts), 8'h01);
      i_i2c_ctrl_model.stop();
      // receive stretch while the holding byte is unread
      cfg.rx_stretch_enable <= 1'b1;
      ad({own, 1'b0}, 1'b0);
      rx(8'($urandom));
      chk({6'h00, scl_oe, st.clock_release_bit}, 8'h02);
      sw(REQ_REL_SET);
      rx(8'($urandom));
      sw(REQ_RX_READ);
      sw(REQ_OVF_CLR);
      sw(REQ_REL_SET);
      full = 0;
      ovf  = 0;
      chk(8'(scl_oe), 8'h00);
      // software clear holds the clock only from the next fall
      sw(REQ_REL_CLR);
      chk(8'(scl_oe), 8'h00);
      fork
         rx(8'($urandom));
         begin
            #5000;
            chk(8'(scl_oe), 8'h01);
            sw(REQ_REL_SET);
         end
      join
      sw(REQ_RX_READ);
      sw(REQ_REL_SET);
      full = 0;
      i_i2c_ctrl_model.stop();
      // wide addressing: mismatch, full match, then repeated start read
      cfg.rx_stretch_enable <= 1'b0;
      cfg.wide_addr_sel     <= 1'b1;
      cfg.own_addr_reg      <= own10;
      ad({WIDE_PREFIX, own10[9:8], 1'b0}, 1'b0);
      xb(own10[7:0] ^ 8'h01, 1'b1);
      chk({6'h00, ack, st.wide_match_flag}, 8'h02);
      ad({WIDE_PREFIX, own10[9:8], 1'b0}, 1'b0);
      xb(own10[7:0], 1'b1);
      chk({6'h00, ack, st.wide_match_flag}, 8'h01);
      ad({WIDE_PREFIX, own10[9:8], 1'b1}, 1'b0);
      sw(REQ_TX_WRITE, d);
      sw(REQ_REL_SET);
      xb(8'hFF, 1'b1);
      chk(r, d);
      i_i2c_ctrl_model.stop();
      test_done();
   end
endmodule : i2c_target_with_clock_stretch_tb
`default_nettype wire
